// File: rtl/afp_device.sv
`timescale 1ns/1ps
`default_nettype none
module afp_device (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  coef_if.dev                             cif,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [afp_pkg::CH_W-1:0]   in_ch_i,
  input  wire logic [afp_pkg::DATA_W-1:0] in_sample_i,
  input  wire afp_pkg::rate_t             rate_i,
  input  wire logic                       lineout_i,
  input  wire logic                       deemph_en_i,
  input  wire logic [afp_pkg::BANK_W-1:0] act_bank_i,
  output logic                            out_valid_o,
  output logic [afp_pkg::CH_W-1:0]        out_ch_o,
  output logic [afp_pkg::DATA_W-1:0]      out_sample_o,
  output logic                            sat_o,
  output logic [afp_pkg::N_CH-1:0]        deemph_o
);
  import afp_pkg::*;
  typedef enum logic {ST_IDLE, ST_MIX} mix_st_t;

  // coefficient store: every bank holds gains, mix gains and levels
  logic [COEF_W-1:0]        gain_q [N_BANK][N_GAIN];
  logic [DATA_W-1:0]        off_q  [N_BANK][N_CH];
  logic [HI_BITS-1:0]       hi_q;
  logic                     rdy_q;
  // per-channel processed values for the output mixer
  logic signed [DATA_W-1:0] proc_q [N_CH];
  // gain stage
  logic                     s1_v_q;
  logic [CH_W-1:0]          s1_ch_q;
  logic signed [DATA_W-1:0] s1_q;
  logic signed [PROD_W-1:0] prod;
  logic                     hi_rate;
  // offset stage
  logic signed [DATA_W:0]   sum;
  logic [DATA_W-1:0]        sat_val;
  logic                     ovf_pos;
  logic                     ovf_neg;
  logic [DATA_W-1:0]        off_sel;
  // mixer
  mix_st_t                  st_q;
  logic [CH_W-1:0]          o_q;
  logic [1:0]               t_q;
  logic signed [PROD_W-1:0] acc_q;
  logic signed [PROD_W-1:0] term;
  logic signed [PROD_W-1:0] acc_d;
  logic [CH_W-1:0]          src;
  logic [GIDX_W-1:0]        mix_idx;
  logic                     last_tap;
  logic                     in_rdy_q;
  logic                     out_v_q;
  logic [CH_W-1:0]          out_ch_q;
  logic [DATA_W-1:0]        out_q;
  logic                     sat_q;
  logic [N_CH-1:0]          deemph_q;

  // channel is pass-through when the rate is high and it is not 1, 2 or 8
  function automatic logic pass_ch(input logic [CH_W-1:0] c, input logic hr);
    return hr && !FULL_HI_MASK[c];
  endfunction

  // reset contents: unity channel gain, unity on each output's first tap
  function automatic logic [COEF_W-1:0] def_gain(input int i);
    logic [COEF_W-1:0] g;
    g = '0;
    if (i < N_CH) begin
      g = UNITY;
    end else if (((i - int'(MIX_BASE)) % TAPS) == 0) begin
      g = UNITY;
    end
    return g;
  endfunction

  assign hi_rate = (rate_i == RATE_176K4) || (rate_i == RATE_192);

  // coefficient download; only coefficients reach the store, never the
  // processing order, so a stray write cannot reroute the datapath
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hi_q <= '0;
      for (int b = 0; b < N_BANK; b++) begin
        for (int i = 0; i < N_GAIN; i++) begin
          gain_q[b][i] <= def_gain(i);
        end
        for (int i = 0; i < N_CH; i++) begin
          off_q[b][i] <= '0;
        end
      end
    end else if (cif.valid && rdy_q) begin
      if (cif.addr < OFF_BASE) begin
        gain_q[cif.bank][cif.addr[GIDX_W-1:0]] <= cif.word[COEF_W-1:0];
      end else if (cif.addr < OFF_END) begin
        if (!cif.sel) begin
          hi_q <= cif.word[HI_BITS-1:0];
        end else begin
          off_q[cif.bank][cif.addr[CH_W-1:0]] <= {hi_q, cif.word};
        end
      end
    end
  end

  // the store takes a word on every cycle once out of reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
    end
  end

  // gain stage: signed 48 by signed 28 into a full 76-bit product
  assign prod = $signed(in_sample_i) *
                $signed(gain_q[act_bank_i][{{(GIDX_W-CH_W){1'b0}}, in_ch_i}]);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s1_v_q  <= 1'b0;
      s1_ch_q <= '0;
      s1_q    <= '0;
    end else begin
      s1_v_q  <= in_valid_i && in_rdy_q;
      s1_ch_q <= in_ch_i;
      s1_q    <= prod[FRAC_W +: DATA_W];
    end
  end

  // offset stage with clamping; a sign-extended 49-bit sum shows overflow
  assign off_sel = off_q[act_bank_i][s1_ch_q];
  assign sum     = {s1_q[DATA_W-1], s1_q} + {off_sel[DATA_W-1], off_sel};
  assign ovf_pos = (sum[DATA_W:DATA_W-1] == 2'b01);
  assign ovf_neg = (sum[DATA_W:DATA_W-1] == 2'b10);

  always_comb begin
    sat_val = sum[DATA_W-1:0];
    if (ovf_pos) begin
      sat_val = SAT_MAX;
    end else if (ovf_neg) begin
      sat_val = SAT_MIN;
    end
  end

  // processed channel store; pass-through channels keep volume only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < N_CH; i++) begin
        proc_q[i] <= '0;
      end
      sat_q <= 1'b0;
    end else begin
      sat_q <= 1'b0;
      if (s1_v_q) begin
        if (pass_ch(s1_ch_q, hi_rate)) begin
          proc_q[s1_ch_q] <= s1_q;
        end else begin
          proc_q[s1_ch_q] <= sat_val;
          sat_q           <= ovf_pos || ovf_neg;
        end
      end
    end
  end

  // mixer tap table is fixed: output o below 6 takes channels o, o+1; outputs 6 and 7 also take o+2
  assign src      = CH_W'(o_q + CH_W'(t_q));
  assign mix_idx  = GIDX_W'(int'(MIX_BASE) + TAPS * int'(o_q) + int'(t_q));
  assign term     = $signed(proc_q[src]) * $signed(gain_q[act_bank_i][mix_idx]);
  assign acc_d    = ((t_q == 2'h0) ? '0 : acc_q) + term;
  assign last_tap = (int'(o_q) < NARROW_OUTS) ? (int'(t_q) == TAPS_NARROW - 1)
                                              : (int'(t_q) == TAPS - 1);

  // mixer walks all outputs after channel 8 of a frame lands; input is
  // held off from the first mix cycle on, so only a sample taken while channel 8 is in the gain stage can still change the stored frame under it
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q     <= ST_IDLE;
      o_q      <= '0;
      t_q      <= '0;
      acc_q    <= '0;
      in_rdy_q <= 1'b0;
      out_v_q  <= 1'b0;
      out_ch_q <= '0;
      out_q    <= '0;
    end else begin
      out_v_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          in_rdy_q <= 1'b1;
          if (s1_v_q && (s1_ch_q == CH_W'(N_CH - 1))) begin
            in_rdy_q <= 1'b0;
            o_q      <= '0;
            t_q      <= '0;
            st_q     <= ST_MIX;
          end
        end
        ST_MIX: begin
          acc_q <= acc_d;
          t_q   <= t_q + 2'h1;
          if (last_tap) begin
            t_q      <= '0;
            out_v_q  <= 1'b1;
            out_ch_q <= o_q;
            if (pass_ch(o_q, hi_rate)) begin
              out_q <= proc_q[o_q];
            end else begin
              out_q <= acc_d[FRAC_W +: DATA_W];
            end
            o_q <= o_q + CH_W'(1);
            if (o_q == CH_W'(N_CH - 1)) begin
              in_rdy_q <= 1'b1;
              st_q     <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // de-emphasis enable per channel; absent above 48 kHz
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      deemph_q <= '0;
    end else if (deemph_en_i && (rate_i == RATE_32 || rate_i == RATE_44K1 ||
                                 rate_i == RATE_48)) begin
      deemph_q <= lineout_i ? DEEMPH_6_MASK : DEEMPH_8_MASK;
    end else begin
      deemph_q <= '0;
    end
  end

  assign cif.ready    = rdy_q;
  assign in_ready_o   = in_rdy_q;
  assign out_valid_o  = out_v_q;
  assign out_ch_o     = out_ch_q;
  assign out_sample_o = out_q;
  assign sat_o        = sat_q;
  assign deemph_o     = deemph_q;
endmodule
`default_nettype wire

// File: rtl/afp_pkg.sv
// Functional notes
// - samples are 48-bit two's-complement, sign on top
// - gain: 48x28 signed product, truncated to 48
// - offset: signed 48-bit add of coefficient
// - positive overflow clamps to 48-bit maximum
// - negative overflow clamps to 48-bit minimum
// - gain coefficients are 28-bit 5.23 signed
// - coefficients are two's complement throughout
// - host sends each gain as one word
// - gain in word bits 27:0, top nibble zero
// - level coefficients are 48-bit 25.23 signed
// - host sends each level as two words
// - mixer sums in a 76-bit accumulator
// - fixed sequence; only coefficients are writable
// - high rates: channels 3-7 get volume only
// - outputs 1-6 mix two, 7-8 three
// - three extra coefficient banks beyond active
// - de-emphasis only at 32/44.1/48 kHz
`default_nettype none
package afp_pkg;
  localparam int DATA_W     = 48;
  localparam int COEF_W     = 28;
  localparam int PROD_W     = 76;
  localparam int FRAC_W     = 23;
  localparam int WORD_W     = 32;
  localparam int HI_BITS    = 16;
  localparam int N_CH       = 8;
  localparam int CH_W       = 3;
  localparam int N_BANK     = 4;
  localparam int BANK_W     = 2;
  localparam int ADDR_W     = 6;
  localparam int GIDX_W     = 5;
  localparam int N_GAIN     = 32;
  localparam int TAPS       = 3;
  localparam int TAPS_NARROW = 2;
  localparam int NARROW_OUTS = 6;
  // coefficient address map
  localparam logic [ADDR_W-1:0] GAIN_BASE = 6'h00;
  localparam logic [ADDR_W-1:0] MIX_BASE  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_BASE  = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_END   = 6'h28;
  localparam logic [DATA_W-1:0] SAT_MAX   = 48'h7fff_ffff_ffff;
  localparam logic [DATA_W-1:0] SAT_MIN   = 48'h8000_0000_0000;
  localparam logic [COEF_W-1:0] UNITY     = 28'h080_0000;
  localparam logic [N_CH-1:0]   FULL_HI_MASK  = 8'h83;
  localparam logic [N_CH-1:0]   DEEMPH_8_MASK = 8'hff;
  localparam logic [N_CH-1:0]   DEEMPH_6_MASK = 8'hcf;
  typedef enum logic [2:0] {
    RATE_32, RATE_44K1, RATE_48, RATE_88K2, RATE_96, RATE_176K4, RATE_192
  } rate_t;
endpackage
`default_nettype wire

// File: rtl/coef_if.sv
`timescale 1ns/1ps
`default_nettype none
// coefficient download link: host pushes 32-bit words, device accepts
interface coef_if;
  logic                       valid;
  logic                       ready;
  logic                       sel;
  logic [afp_pkg::WORD_W-1:0] word;
  logic [afp_pkg::ADDR_W-1:0] addr;
  logic [afp_pkg::BANK_W-1:0] bank;
  modport dev  (input valid, sel, word, addr, bank, output ready);
  modport host (output valid, sel, word, addr, bank, input ready);
endinterface
`default_nettype wire

// File: rtl/afp_host.sv
`timescale 1ns/1ps
`default_nettype none
module afp_host (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  coef_if.host                            cif,
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic [afp_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [afp_pkg::BANK_W-1:0] req_bank_i,
  input  wire logic [afp_pkg::DATA_W-1:0] req_value_i,
  output logic                            done_o
);
  import afp_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_W0, ST_W1} host_st_t;

  host_st_t            st_q;
  logic                rdy_q;
  logic                done_q;
  logic                vld_q;
  logic                sel_q;
  logic                two_q;
  logic [WORD_W-1:0]   word_q;
  logic [WORD_W-1:0]   low_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [BANK_W-1:0]   bank_q;
  logic                two_d;

  // level coefficients travel as two words, everything else as one
  assign two_d = (req_addr_i >= OFF_BASE) && (req_addr_i < OFF_END);

  // word sequencer; a new request is only taken once the last word is gone
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q   <= ST_IDLE;
      rdy_q  <= 1'b0;
      done_q <= 1'b0;
      vld_q  <= 1'b0;
      sel_q  <= 1'b0;
      two_q  <= 1'b0;
      word_q <= '0;
      low_q  <= '0;
      addr_q <= '0;
      bank_q <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          rdy_q <= 1'b1;
          if (req_valid_i && rdy_q) begin
            rdy_q  <= 1'b0;
            vld_q  <= 1'b1;
            sel_q  <= 1'b0;
            two_q  <= two_d;
            addr_q <= req_addr_i;
            bank_q <= req_bank_i;
            low_q  <= req_value_i[WORD_W-1:0];
            if (two_d) begin
              word_q <= {{(WORD_W-HI_BITS){1'b0}}, req_value_i[DATA_W-1:WORD_W]};
            end else begin
              word_q <= {{(WORD_W-COEF_W){1'b0}}, req_value_i[COEF_W-1:0]};
            end
            st_q <= ST_W0;
          end
        end
        ST_W0: begin
          if (cif.ready) begin
            if (two_q) begin
              word_q <= low_q;
              sel_q  <= 1'b1;
              st_q   <= ST_W1;
            end else begin
              vld_q  <= 1'b0;
              done_q <= 1'b1;
              st_q   <= ST_IDLE;
            end
          end
        end
        ST_W1: begin
          if (cif.ready) begin
            vld_q  <= 1'b0;
            sel_q  <= 1'b0;
            done_q <= 1'b1;
            st_q   <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign cif.valid   = vld_q;
  assign cif.sel     = sel_q;
  assign cif.word    = word_q;
  assign cif.addr    = addr_q;
  assign cif.bank    = bank_q;
  assign req_ready_o = rdy_q;
  assign done_o      = done_q;
endmodule
`default_nettype wire

// File: dv/afp_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
// link-level checks on the coefficient download wires
module afp_link_sva (
  input wire logic                       core_clk_i,
  input wire logic                       sys_rst_i,
  input wire logic                       valid,
  input wire logic                       ready,
  input wire logic                       sel,
  input wire logic [afp_pkg::WORD_W-1:0] word,
  input wire logic [afp_pkg::ADDR_W-1:0] addr,
  input wire logic [afp_pkg::BANK_W-1:0] bank
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic lvl;
  // level slots need two words, all others one
  assign lvl = addr inside {[6'h20:6'h27]};
  a_word_held: assert property (valid && !ready |=> valid && $stable({sel, word, addr, bank}))
    else $error("word moved while stalled");
  a_gain_nibble_zero: assert property (valid && addr < 6'h20 |-> word[31:28] == 4'h0)
    else $error("gain word top nibble not zero");
  a_level_hi_zero: assert property (valid && !sel && lvl |-> word[31:16] == 16'h0000)
    else $error("level upper word not right aligned");
  a_level_pairs: assert property (valid && ready && !sel && lvl |=> valid && sel && $stable(addr))
    else $error("level upper word not followed by lower");
  a_lower_follows: assert property (valid && sel && $past(ready) |-> $past(valid && !sel))
    else $error("lower word without upper");
  a_gain_one_word: assert property (valid && ready && addr < 6'h20 |=> !(valid && sel))
    else $error("gain sent as more than one word");
  a_no_third_word: assert property (valid && ready && sel |=> !(valid && sel))
    else $error("level sent as more than two words");
  a_ready_after_rst: assert property ($fell(sys_rst_i) |=> ready)
    else $error("ready not up after reset");
endmodule
`default_nettype wire

// File: dv/audio_fixed_point_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module audio_fixed_point_datapath_tb_top;
  import afp_pkg::*;
  logic               core_clk_i, sys_rst_i, req_valid_i, req_ready_o, done_o;
  logic [5:0]         req_addr_i;
  logic [1:0]         req_bank_i, act_bank_i;
  logic [47:0]        req_value_i, in_sample_i, out_sample_o;
  logic               in_valid_i, in_ready_o, lineout_i, deemph_en_i, out_valid_o, sat_o;
  logic [2:0]         in_ch_i, out_ch_o;
  logic [7:0]         deemph_o;
  rate_t              rate_i;
  logic signed [27:0] gn [4][32];
  logic signed [47:0] lv [4][8];
  logic [47:0]        smp [8], exp_o [8], got [8];
  int                 n_out, n_sat, nsat_exp, num_errors, checks_done;
  coef_if link ();
  afp_host afp_host_i (.core_clk_i, .sys_rst_i, .cif(link), .req_valid_i, .req_ready_o,
    .req_addr_i, .req_bank_i, .req_value_i, .done_o);
  afp_device afp_device_i (.core_clk_i, .sys_rst_i, .cif(link), .in_valid_i, .in_ready_o,
    .in_ch_i, .in_sample_i, .rate_i, .lineout_i, .deemph_en_i, .act_bank_i, .out_valid_o,
    .out_ch_o, .out_sample_o, .sat_o, .deemph_o);
  afp_link_sva afp_link_sva_i (.core_clk_i, .sys_rst_i, .valid(link.valid), .ready(link.ready),
    .sel(link.sel), .word(link.word), .addr(link.addr), .bank(link.bank));
  initial begin
    core_clk_i = 0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // collect outputs by channel; sat pulses are counted per frame
  always @(posedge core_clk_i) begin
    if (out_valid_o === 1'b1) begin
      got[out_ch_o] <= out_sample_o;
      n_out <= n_out + 1;
    end
    if (sat_o === 1'b1) n_sat <= n_sat + 1;
  end
  function automatic logic [47:0] trunc(input logic signed [75:0] p);
    return p[70:23];
  endfunction
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // reference model of the active bank, built only from our own write log
  task automatic calc();
    logic signed [47:0] pr [8];
    logic signed [48:0] sum;
    logic signed [75:0] acc;
    logic signed [75:0] p;
    bit                 hi;
    hi = rate_i >= RATE_176K4;
    nsat_exp = 0;
    for (int k = 0; k < 8; k++) begin
      // full 76-bit product first, so no operand width decides the size
      p = $signed(smp[k]) * gn[act_bank_i][k];
      pr[k] = trunc(p);
      sum = pr[k] + lv[act_bank_i][k];
      if (!(hi && k inside {[2:6]})) begin
        pr[k] = (sum[48] != sum[47]) ? (sum[48] ? SAT_MIN : SAT_MAX) : sum[47:0];
        nsat_exp += int'(sum[48] != sum[47]);
      end
    end
    for (int o = 0; o < 8; o++) begin
      acc = 0;
      for (int t = 0; t < (o < 6 ? 2 : 3); t++) acc += pr[(o + t) % 8] * gn[act_bank_i][8 + 3 * o + t];
      exp_o[o] = (hi && o inside {[2:6]}) ? pr[o] : trunc(acc);
    end
  endtask
  // one host request, waits for the done pulse; model mirrors the store
  task automatic wr(input logic [5:0] a, input logic [1:0] b, input logic [47:0] v);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    {req_valid_i, req_addr_i, req_bank_i, req_value_i} = {1'b1, a, b, v};
    @(negedge core_clk_i);
    req_valid_i = 0;
    while (done_o !== 1'b1 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    chk("write done", 48'(done_o), 48'h1);
    if (a < 6'h20) gn[b][a] = v[27:0];
    else if (a < 6'h28) lv[b][a - 6'h20] = v;
  endtask
  // push channels 0..7 back to back, then compare all eight outputs
  task automatic frame(input string nm);
    int n;
    calc();
    n_out = 0;
    n_sat = 0;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      @(negedge core_clk_i);
      while (in_ready_o !== 1'b1 && n < 80) begin
        @(negedge core_clk_i);
        n++;
      end
      {in_valid_i, in_ch_i, in_sample_i} = {1'b1, 3'(k), smp[k]};
    end
    @(negedge core_clk_i);
    in_valid_i = 0;
    for (n = 0; n < 100 && n_out < 8; n++) @(negedge core_clk_i);
    chk("output count", 48'(n_out), 48'd8);
    for (int o = 0; o < 8; o++) chk(nm, got[o], exp_o[o]);
    chk("sat count", 48'(n_sat), 48'(nsat_exp));
  endtask
  task automatic deemph_sweep();
    logic [7:0] e;
    for (int r = 0; r < 7; r++) begin
      for (int l = 0; l < 2; l++) begin
        rate_i    = rate_t'(r);
        lineout_i = l[0];
        repeat (3) @(negedge core_clk_i);
        e = (r > 2) ? 8'h00 : (l != 0) ? DEEMPH_6_MASK : DEEMPH_8_MASK;
        chk("deemph", 48'(deemph_o), 48'(e));
      end
    end
    deemph_en_i = 0;
    repeat (3) @(negedge core_clk_i);
    chk("deemph off", 48'(deemph_o), 48'h0);
    rate_i    = RATE_48;
    lineout_i = 1'b0;
  endtask
  // a hung handshake is cut short well past the longest expected run
  initial begin
    #300000;
    num_errors++;
    end_of_test();
  end
  initial begin
    {sys_rst_i, req_valid_i, req_addr_i, req_bank_i, req_value_i} = {1'b1, 57'h0};
    {in_valid_i, in_ch_i, in_sample_i, lineout_i, act_bank_i} = {55'h0};
    rate_i      = RATE_48;
    deemph_en_i = 1'b1;
    for (int b = 0; b < 4; b++) begin
      for (int a = 0; a < 32; a++) gn[b][a] = (a < 8 || (a - 8) % 3 == 0) ? UNITY : '0;
      for (int a = 0; a < 8; a++) lv[b][a] = '0;
    end
    for (int k = 0; k < 8; k++) smp[k] = {{16{k[0]}}, 32'h1357_9bd0 + 32'(k)};
    repeat (5) @(negedge core_clk_i);
    sys_rst_i = 0;
    repeat (2) @(negedge core_clk_i);
    frame("default pass");
    wr(6'h00, 2'h0, 48'h0000_0040_0000);
    wr(6'h01, 2'h0, 48'hffff_ff00_0000);
    frame("gain half and minus two");
    wr(6'h22, 2'h0, 48'h7fff_ffff_ffff);
    wr(6'h23, 2'h0, 48'h8000_0000_0000);
    wr(6'h24, 2'h0, 48'h0001_0000_0003);
    frame("offset clamp");
    wr(6'h1b, 2'h0, 48'(UNITY));
    wr(6'h0a, 2'h0, 48'(UNITY));
    frame("mixer taps");
    rate_i = RATE_192;
    frame("high rate");
    rate_i = RATE_48;
    wr(6'h28, 2'h0, 48'h0000_0123_4567);
    wr(6'h05, 2'h1, 48'h0000_00c0_0000);
    frame("bank 0 kept");
    act_bank_i = 2'h1;
    frame("bank 1 live");
    act_bank_i = 2'h0;
    deemph_sweep();
    end_of_test();
  end
endmodule
`default_nettype wire
